// >>> design/adc_cfg_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the mode configuration port.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only; no logic lives here.
`ifndef ADC_CFG_DEFS_SVH
`define ADC_CFG_DEFS_SVH

// ============================================================
// Register addresses (seven-bit address field)
// ============================================================
`define ADC_CFG_ADDR_SW_RESET     7'h00
`define ADC_CFG_ADDR_POWER_DOWN   7'h01
`define ADC_CFG_ADDR_OUT_TIMING   7'h02

// ============================================================
// Reset values and field positions
// ============================================================
`define ADC_CFG_REG_RESET         8'h00
`define ADC_CFG_SW_RESET_BIT      7
`define ADC_CFG_PWR_SEL_MSB       1
`define ADC_CFG_PWR_SEL_LSB       0
`define ADC_CFG_DCS_BIT           0
`define ADC_CFG_PHASE_MSB         2
`define ADC_CFG_PHASE_LSB         1
`define ADC_CFG_CLK_INV_BIT       3

// ============================================================
// Serial word layout and counts
// ============================================================
`define ADC_CFG_WORD_BITS         5'h10
`define ADC_CFG_HDR_BITS          5'h08
`define ADC_CFG_RNW_POS           15
`define ADC_CFG_ADDR_MSB          14
`define ADC_CFG_ADDR_LSB          8

// ============================================================
// Power state and output mode codes
// ============================================================
`define ADC_CFG_PWR_NORMAL        2'h0
`define ADC_CFG_PWR_NAP           2'h1
`define ADC_CFG_PWR_SLEEP         2'h3
`define ADC_CFG_OUT_CMOS_FULL     2'h0
`define ADC_CFG_OUT_LVDS_DDR      2'h1

`endif

// >>> design/adc_cfg_pkg.sv
// Purpose: Types shared by the mode configuration port.
// Assumes: Used only through scoped names.
// Notes:   Constants live in the defs header.
package adc_cfg_pkg;

    // ============================================================
    // Serial engine states
    // ============================================================
    // Idle waits for a select fall; shift collects the word.
    typedef enum logic {
        SER_IDLE,
        SER_SHIFT
    } ser_state_t;

endpackage

// >>> design/cfg_pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk_i; each bit is a level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps

module cfg_pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    // ============================================================
    // Synchroniser stages
    // ============================================================
    logic [WIDTH-1:0] meta_r;   // First stage, may go metastable.
    logic [WIDTH-1:0] meta_nxt; // Next value of the first stage.
    logic [WIDTH-1:0] q_nxt;    // Next value of the second stage.

    // Next values follow the pins while enabled, else hold.
    always_comb begin
        meta_nxt = ce_i ? d_i : meta_r;
        q_nxt    = ce_i ? meta_r : q_o;
    end

    // Registers only; reset loads zero so no pin reaches a reset path.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_o    <= q_nxt;
        end
    end

endmodule // cfg_pin_sync

// >>> design/adc_mode_config_port.sv
// Purpose: Mode configuration port of a converter, pin-strapped or serial.
// Assumes: ref_clk_i is much faster than the serial clock; all pins are asynchronous.
// Notes:   Serial clock edges are found by oversampling, so its rate must stay well below ref_clk_i / 4.
//          Registers 03h and 04h are held elsewhere.
//          A mode change in mid-frame drops the frame.
`timescale 1ns/1ps
`include "adc_cfg_defs.svh"

// Overview of operation
// - Mode select high: pins are static mode bits.
// - Parallel: chip select drives stabilizer enable.
// - Parallel: SCK picks CMOS or DDR LVDS output.
// - Parallel: SDI high selects sleep mode.
// - Mode select low: pins form serial port.
// - Select fall starts; first 16 rises sampled.
// - Word: read flag, 7-bit address, 8 data.
// - Write flag stores data at address.
// - Read flag returns addressed register on SDO.
// - Read leaves register unchanged, ignores SDI data.
// - SDO open drain: drives low only.
// - Reset bit clears every mode register.
// - Reset bit self-clears after its write.
// - Reset register write-only; low bits ignored.
// - Phase field delays output clock 0-135 degrees.
// - Timing bit 0 enables duty cycle stabilizer.
// - Invert bit flips output clock polarity.
module adc_mode_config_port (
    input  wire logic       ref_clk_i,                      // System clock, 125 MHz.
    input  wire logic       sys_rst_i,                      // Synchronous reset, active high.
    input  wire logic       clk_en_i,                       // Freezes all state while low.
    input  wire logic       programming_mode_select_i,      // High: parallel straps, low: serial.
    input  wire logic       cs_n_i,                         // Chip select pin, active low in serial mode.
    input  wire logic       sck_i,                          // Serial clock pin.
    input  wire logic       sdi_i,                          // Serial data in pin.
    input  wire logic       sdo_i,                          // Level seen on the shared data out wire.
    output logic            sdo_o,                          // Value driven on data out, always zero.
    output logic            sdo_oe_o,                       // High while pulling data out low.
    output logic            duty_cycle_stabilizer_enable_o, // Stabilizer on when high.
    output logic [1:0]      output_clock_phase_select_o,    // Output clock delay code.
    output logic            output_clock_invert_o,          // Output clock polarity flip.
    output logic [1:0]      power_state_select_o,           // Power state code.
    output logic [1:0]      output_mode_o                   // Output mode code, CMOS or LVDS.
);

    // ============================================================
    // Pin synchronisation
    // ============================================================
    logic [3:0] pins_s;   // Synchronised {mode, select, sck, sdi}.
    logic       mode_s;   // Synchronised programming mode select.
    logic       cs_n_s;   // Synchronised chip select.
    logic       sck_s;    // Synchronised serial clock.
    logic       sdi_s;    // Synchronised serial data.

    logic       sdo_seen; // Wire level is only informative here.

    // All four pins cross with two flops before any logic reads them.
    cfg_pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clk_i (ref_clk_i),
        .rst_i (sys_rst_i),
        .ce_i  (clk_en_i),
        .d_i   ({programming_mode_select_i, cs_n_i, sck_i, sdi_i}),
        .q_o   (pins_s)
    );

    // Unpack the synchronised group.
    always_comb begin
        mode_s   = pins_s[3];
        cs_n_s   = pins_s[2];
        sck_s    = pins_s[1];
        sdi_s    = pins_s[0];

        sdo_seen = sdo_i;
    end

    // ============================================================
    // State
    // ============================================================
    // Frame engine.
    adc_cfg_pkg::ser_state_t state_r, state_nxt; // Serial engine state.
    logic [4:0]  cnt_r, cnt_nxt;         // Rising edges sampled in this frame.
    logic [15:0] sh_r, sh_nxt;           // Incoming word, first bit ends in the MSB.
    logic        rnw_r, rnw_nxt;         // Read flag of the current frame.
    logic [7:0]  rd_r, rd_nxt;           // Read data still to be shifted out.
    logic        sck_d_r, sck_d_nxt;     // Previous serial clock sample, for edges.
    logic        cs_d_r, cs_d_nxt;       // Previous select sample, for the start edge.

    // Stored fields.
    logic [1:0]  pwr_r, pwr_nxt;         // Power-down register, used bits only.
    logic [3:0]  tim_r, tim_nxt;         // Timing register, used bits only.

    // Next outputs.
    logic        oe_nxt;                 // Next data out enable.
    logic        dcs_nxt;                // Next stabilizer enable output.
    logic [1:0]  phase_nxt;              // Next phase output.
    logic        inv_nxt;                // Next invert output.
    logic [1:0]  pstate_nxt;             // Next power state output.
    logic [1:0]  omode_nxt;              // Next output mode output.

    // Link edges.
    logic        sck_rise;               // Serial clock rose this cycle.
    logic        sck_fall;               // Serial clock fell this cycle.

    // Read-back value of an address; unmapped and write-only ones read zero.
    function automatic logic [7:0] reg_read(input logic [6:0] addr,
                                            input logic [1:0] pwr,
                                            input logic [3:0] tim);
        logic [7:0] val;

        val = `ADC_CFG_REG_RESET;
        if (addr == `ADC_CFG_ADDR_POWER_DOWN) begin
            val[`ADC_CFG_PWR_SEL_MSB:`ADC_CFG_PWR_SEL_LSB] = pwr;
        end else if (addr == `ADC_CFG_ADDR_OUT_TIMING) begin
            val[3:0] = tim;
        end

        return val;
    endfunction

    // ============================================================
    // Serial engine and register file
    // ============================================================
    // Read bits change on falls, so they settle before the next rise.
    // Next-state logic for the frame, the registers and the data out enable.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        sh_nxt    = sh_r;
        rnw_nxt   = rnw_r;
        rd_nxt    = rd_r;
        pwr_nxt   = pwr_r;
        tim_nxt   = tim_r;
        oe_nxt    = sdo_oe_o;
        sck_d_nxt = sck_s;
        cs_d_nxt  = cs_n_s;

        sck_rise  = sck_s & ~sck_d_r;
        sck_fall  = ~sck_s & sck_d_r;

        if (mode_s) begin
            state_nxt = adc_cfg_pkg::SER_IDLE;
            cnt_nxt   = '0;
            oe_nxt    = 1'b0;
        end else begin
            unique case (state_r)
                adc_cfg_pkg::SER_IDLE: begin
                    if (!cs_n_s && cs_d_r) begin
                        state_nxt = adc_cfg_pkg::SER_SHIFT;
                        cnt_nxt   = '0;
                        rnw_nxt   = 1'b0;
                    end
                end

                adc_cfg_pkg::SER_SHIFT: begin
                    if (cs_n_s) begin
                        // Frame ends; the line is always released here.
                        state_nxt = adc_cfg_pkg::SER_IDLE;
                        oe_nxt    = 1'b0;
                        if (cnt_r == `ADC_CFG_WORD_BITS && !sh_r[`ADC_CFG_RNW_POS]) begin
                            unique case (sh_r[`ADC_CFG_ADDR_MSB:`ADC_CFG_ADDR_LSB])
                                `ADC_CFG_ADDR_SW_RESET: begin
                                    if (sh_r[`ADC_CFG_SW_RESET_BIT]) begin
                                        pwr_nxt = '0;
                                        tim_nxt = '0;
                                    end
                                end

                                `ADC_CFG_ADDR_POWER_DOWN: begin
                                    pwr_nxt = sh_r[`ADC_CFG_PWR_SEL_MSB:`ADC_CFG_PWR_SEL_LSB];
                                end

                                `ADC_CFG_ADDR_OUT_TIMING: begin
                                    tim_nxt = sh_r[3:0];
                                end

                                default: begin
                                    // Unmapped addresses accept and drop the data.
                                end
                            endcase
                        end
                    end else if (sck_rise && cnt_r < `ADC_CFG_WORD_BITS) begin
                        sh_nxt  = {sh_r[14:0], sdi_s};
                        cnt_nxt = cnt_r + 5'h01;

                        if (cnt_r == 5'h00) begin
                            rnw_nxt = sdi_s;
                        end

                        if (cnt_r == `ADC_CFG_HDR_BITS - 5'h01) begin
                            rd_nxt = reg_read({sh_r[5:0], sdi_s}, pwr_r, tim_r);
                        end
                    end else if (sck_fall && cnt_r >= `ADC_CFG_HDR_BITS) begin
                        if (cnt_r < `ADC_CFG_WORD_BITS) begin
                            oe_nxt = rnw_r & ~rd_r[7];
                            rd_nxt = {rd_r[6:0], 1'b0};
                        end else begin
                            oe_nxt = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Mode outputs
    // ============================================================
    // Outputs come from pins in parallel mode (phase and invert zero) and from registers otherwise (output mode fixed at CMOS).
    always_comb begin
        if (mode_s) begin
            dcs_nxt    = cs_n_s;

            omode_nxt  = sck_s ? `ADC_CFG_OUT_LVDS_DDR : `ADC_CFG_OUT_CMOS_FULL;

            pstate_nxt = sdi_s ? `ADC_CFG_PWR_SLEEP : `ADC_CFG_PWR_NORMAL;

            phase_nxt  = 2'h0;
            inv_nxt    = 1'b0;
        end else begin
            dcs_nxt    = tim_nxt[`ADC_CFG_DCS_BIT];

            phase_nxt  = tim_nxt[`ADC_CFG_PHASE_MSB:`ADC_CFG_PHASE_LSB];

            inv_nxt    = tim_nxt[`ADC_CFG_CLK_INV_BIT];

            pstate_nxt = pwr_nxt;

            // Output mode lives in a register not held by this block.
            omode_nxt  = `ADC_CFG_OUT_CMOS_FULL;
        end
    end

    // Registers only; the clock enable freezes every one of them.
    // The data out value itself is always zero.
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_r                        <= adc_cfg_pkg::SER_IDLE;
            cnt_r                          <= '0;
            sh_r                           <= '0;
            rnw_r                          <= 1'b0;
            rd_r                           <= '0;
            sck_d_r                        <= 1'b0;
            // Low as the sync resets low: no false fall.
            cs_d_r                         <= 1'b0;
            pwr_r                          <= '0;
            tim_r                          <= '0;

            sdo_o                          <= 1'b0;
            sdo_oe_o                       <= 1'b0;
            duty_cycle_stabilizer_enable_o <= 1'b0;
            output_clock_phase_select_o    <= 2'h0;
            output_clock_invert_o          <= 1'b0;
            power_state_select_o           <= `ADC_CFG_PWR_NORMAL;
            output_mode_o                  <= `ADC_CFG_OUT_CMOS_FULL;
        end else if (clk_en_i) begin
            state_r                        <= state_nxt;
            cnt_r                          <= cnt_nxt;
            sh_r                           <= sh_nxt;
            rnw_r                          <= rnw_nxt;
            rd_r                           <= rd_nxt;
            sck_d_r                        <= sck_d_nxt;
            cs_d_r                         <= cs_d_nxt;
            pwr_r                          <= pwr_nxt;
            tim_r                          <= tim_nxt;

            sdo_o                          <= 1'b0;
            sdo_oe_o                       <= oe_nxt;
            duty_cycle_stabilizer_enable_o <= dcs_nxt;
            output_clock_phase_select_o    <= phase_nxt;
            output_clock_invert_o          <= inv_nxt;
            power_state_select_o           <= pstate_nxt;
            output_mode_o                  <= omode_nxt;
        end
    end

endmodule // adc_mode_config_port

// >>> tb/adc_mode_config_port_assertions.sv
// Purpose: Port-level assertions for the mode configuration port.
// Assumes: Pins settle on whole ref clocks; data out wire has a pull-up.
// Notes:   Latencies allow two sync stages plus one output stage.
`timescale 1ns/1ps

module adc_mode_config_port_assertions (
    input wire logic       ref_clk_i,
    input wire logic       sys_rst_i,
    input wire logic       clk_en_i,
    input wire logic       programming_mode_select_i,
    input wire logic       cs_n_i,
    input wire logic       sck_i,
    input wire logic       sdi_i,
    input wire logic       sdo_i,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o,
    input wire logic       duty_cycle_stabilizer_enable_o,
    input wire logic [1:0] output_clock_phase_select_o,
    input wire logic       output_clock_invert_o,
    input wire logic [1:0] power_state_select_o,
    input wire logic [1:0] output_mode_o
);
    // ============================================================
    // Properties
    // ============================================================
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Open drain: the pin value is never a driven high.
    property p_sdo_low_only; !sdo_o; endproperty
    a_sdo_low_only: assert property (p_sdo_low_only) else $error("data out driven high");
    // No pull-down outside a selected serial frame, allowing sync delay.
    property p_oe_idle;
        (clk_en_i && (cs_n_i || programming_mode_select_i))[*6] |-> !sdo_oe_o;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data out pulled outside frame");
    property p_par_dcs;
        (programming_mode_select_i && clk_en_i && $stable(cs_n_i))[*4]
            |=> duty_cycle_stabilizer_enable_o == $past(cs_n_i);
    endproperty
    a_par_dcs: assert property (p_par_dcs) else $error("stabilizer strap not followed");
    property p_par_mode;
        (programming_mode_select_i && clk_en_i && $stable(sck_i))[*4] |=> output_mode_o == {1'b0, $past(sck_i)};
    endproperty
    a_par_mode: assert property (p_par_mode) else $error("output mode strap not followed");
    property p_par_power;
        (programming_mode_select_i && clk_en_i && $stable(sdi_i))[*4]
            |=> power_state_select_o == {2{$past(sdi_i)}} && output_clock_phase_select_o == 2'h0
                && !output_clock_invert_o;
    endproperty
    a_par_power: assert property (p_par_power) else $error("sleep strap not followed");
    property p_ser_mode; (!programming_mode_select_i && clk_en_i)[*4] |=> output_mode_o == 2'h0; endproperty
    a_ser_mode: assert property (p_ser_mode) else $error("output mode not fixed in serial");
    // Register outputs only move after a frame has closed.
    property p_frame_hold;
        (!programming_mode_select_i && clk_en_i && !cs_n_i)[*5] |=> $stable({output_clock_phase_select_o,
            output_clock_invert_o, power_state_select_o, duty_cycle_stabilizer_enable_o});
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("outputs moved inside frame");
    property p_reset_clear;
        $fell(sys_rst_i) |-> {sdo_oe_o, duty_cycle_stabilizer_enable_o, output_clock_phase_select_o,
            output_clock_invert_o, power_state_select_o, output_mode_o} == 9'h000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");

    // Main scenarios seen.
    c_read_bit: cover property (!sdo_oe_o ##1 sdo_oe_o);
    c_nap: cover property (power_state_select_o == 2'h1);
    c_lvds: cover property (output_mode_o == 2'h1);
endmodule // adc_mode_config_port_assertions

bind adc_mode_config_port adc_mode_config_port_assertions u_adc_mode_config_port_assertions (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .programming_mode_select_i(programming_mode_select_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .sdi_i(sdi_i), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .duty_cycle_stabilizer_enable_o(duty_cycle_stabilizer_enable_o),
    .output_clock_phase_select_o(output_clock_phase_select_o), .output_clock_invert_o(output_clock_invert_o),
    .power_state_select_o(power_state_select_o), .output_mode_o(output_mode_o));

// >>> tb/spi_cfg_master.sv
// Purpose: Serial controller and strap model facing the configuration pins.
// Assumes: Tasks are called from the bench; pins move just after ref clock edges.
// Notes:   The link clock idles low between frames; read bits are taken before each rise.
`timescale 1ns/1ps

module spi_cfg_master (
    input  wire logic ref_clk_i,
    input  wire logic sdo_line_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      sdi_o
);
    // ============================================================
    // Pin drivers
    // ============================================================
    localparam int HALF = 10;  // Half of a 160 ns link period, in ref clocks.

    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        sdi_o  = 1'b0;
    end

    // Static levels for the strapped mode: select, clock, data.
    task automatic strap(input logic [2:0] v);
        @(posedge ref_clk_i);
        {cs_n_o, sck_o, sdi_o} <= v;
    endtask

    // One framed word, MSB first, with nbits rises.
    task automatic xfer(input logic [15:0] w, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge ref_clk_i);
        cs_n_o <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi_o <= (i < 16) ? w[15-i] : ~w[0];
            repeat (HALF - 1) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line_i};
            @(posedge ref_clk_i);
            sck_o <= 1'b1;
            repeat (HALF) @(posedge ref_clk_i);
            sck_o <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        sdi_o  <= ~sdi_o;  // A released line must not keep showing the last bit.
        repeat (HALF) @(posedge ref_clk_i);
    endtask
endmodule // spi_cfg_master

// >>> tb/adc_mode_config_port_tb.sv
// Purpose: Self-checking bench for the mode configuration port.
// Assumes: Pull-up on the shared data out wire.
// Notes:   Every scenario is its own task and judges its own results.
`timescale 1ns/1ps
`include "adc_cfg_defs.svh"

module adc_mode_config_port_tb;
    // ============================================================
    // Signals and counters
    // ============================================================
    logic       ref_clk_i, sys_rst_i, clk_en_i, mode_sel;
    logic       cs_n, sck, sdi, sdo_o, sdo_oe_o, duty_cycle_stabilizer_enable, inv;
    logic [1:0] phase, pwr, omode;
    wire        sdo_line = sdo_oe_o ? 1'b0 : 1'b1;  // Pull-up resolves the wire.
    wire  [7:0] outs     = {omode, inv, phase, duty_cycle_stabilizer_enable, pwr};
    int         n_fail, tests_run;

    adc_mode_config_port u_adc_mode_config_port (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .programming_mode_select_i(mode_sel), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi),
        .sdo_i(sdo_line), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .duty_cycle_stabilizer_enable_o(duty_cycle_stabilizer_enable),
        .output_clock_phase_select_o(phase), .output_clock_invert_o(inv),
        .power_state_select_o(pwr), .output_mode_o(omode));
    spi_cfg_master u_spi_cfg_master (
        .ref_clk_i(ref_clk_i), .sdo_line_i(sdo_line), .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));

    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        u_spi_cfg_master.xfer({1'b0, a, d}, 16, unused);
    endtask
    // The data field carries ones, which a read must ignore.
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_spi_cfg_master.xfer({1'b1, a, 8'hff}, 16, v);
        chk(v, exp);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic t_start();
        chk(outs, 8'h00);
        chk({7'h00, sdo_o}, 8'h00);
        wr(`ADC_CFG_ADDR_SW_RESET, 8'h80);
        rd_chk(`ADC_CFG_ADDR_POWER_DOWN, 8'h00);
        rd_chk(`ADC_CFG_ADDR_OUT_TIMING, 8'h00);
        $display("test start done");
    endtask
    task automatic t_power();
        logic [1:0] c [3] = '{`ADC_CFG_PWR_NORMAL, `ADC_CFG_PWR_NAP, `ADC_CFG_PWR_SLEEP};
        foreach (c[i]) begin
            wr(`ADC_CFG_ADDR_POWER_DOWN, {6'h3f, c[i]});
            chk(outs, {6'h00, c[i]});
            rd_chk(`ADC_CFG_ADDR_POWER_DOWN, {6'h00, c[i]});
        end
        wr(7'h05, 8'hff);
        chk(outs, 8'h03);
        rd_chk(7'h05, 8'h00);
        $display("test power done");
    endtask
    task automatic t_timing();
        for (int i = 0; i < 16; i++) begin
            if (i[2:1] != 2'h0 && !i[0]) continue;  // Nonzero phase always with stabilizer on.
            wr(`ADC_CFG_ADDR_OUT_TIMING, {4'hf, i[3:0]});
            chk(outs, {2'h0, i[3:0], 2'h3});
            rd_chk(`ADC_CFG_ADDR_OUT_TIMING, {4'h0, i[3:0]});
        end
        $display("test timing done");
    endtask
    task automatic t_frames();
        logic [7:0] v;
        wr(`ADC_CFG_ADDR_POWER_DOWN, 8'h01);
        u_spi_cfg_master.xfer({1'b1, 7'h01, 8'hff}, 16, v);
        chk(v, 8'h01);
        chk({6'h00, pwr}, 8'h01);
        u_spi_cfg_master.xfer({1'b0, 7'h01, 8'h03}, 10, v);
        chk({6'h00, pwr}, 8'h01);
        u_spi_cfg_master.xfer({1'b0, 7'h01, 8'h03}, 20, v);
        chk({6'h00, pwr}, 8'h03);
        $display("test frames done");
    endtask
    task automatic t_soft_reset();
        wr(`ADC_CFG_ADDR_SW_RESET, 8'h7f);
        chk(outs, 8'h3f);
        wr(`ADC_CFG_ADDR_SW_RESET, 8'h80);
        chk(outs, 8'h00);
        rd_chk(`ADC_CFG_ADDR_POWER_DOWN, 8'h00);
        rd_chk(`ADC_CFG_ADDR_OUT_TIMING, 8'h00);
        rd_chk(`ADC_CFG_ADDR_SW_RESET, 8'h00);
        wr(`ADC_CFG_ADDR_POWER_DOWN, 8'h01);
        chk(outs, 8'h01);
        $display("test soft reset done");
    endtask
    task automatic t_parallel();
        wr(`ADC_CFG_ADDR_POWER_DOWN, 8'h01);
        mode_sel <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            u_spi_cfg_master.strap(s[2:0]);
            repeat (6) @(posedge ref_clk_i);
            chk(outs, {1'b0, s[1], 3'h0, s[2], {2{s[0]}}});
        end
        clk_en_i <= 1'b0;
        u_spi_cfg_master.strap(3'h0);
        repeat (6) @(posedge ref_clk_i);
        chk(outs, 8'h47);
        clk_en_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        chk(outs, 8'h00);
        u_spi_cfg_master.strap(3'h4);
        repeat (6) @(posedge ref_clk_i);
        mode_sel <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        chk(outs, 8'h01);
        $display("test parallel done");
    endtask

    // ============================================================
    // Clock, sequence and watchdog
    // ============================================================
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        sys_rst_i = 1'b1;
        clk_en_i  = 1'b1;
        mode_sel  = 1'b0;
        n_fail    = 0;
        tests_run = 0;
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        t_start();
        t_power();
        t_timing();
        t_frames();
        t_soft_reset();
        t_parallel();
        tally_and_finish();
    end
    // About 45 frames of 350 clocks each; the limit leaves ample margin.
    initial begin
        #500us;
        n_fail++;
        tally_and_finish();
    end
endmodule // adc_mode_config_port_tb
